// *** verilog/drum_serial_integrator_core.sv ***
/*
  Bit-serial datapath of the drum integrator core, run on the drum clock track.
  Assumes drumClk is the clock-track pulse, track reads are valid on each
  edge and writes are taken by the head on the next; control pins are async.
*/
`timescale 1ns/1ps
module drum_serial_integrator_core
  import dsi_pkg::*;
#(
  parameter int DY_MAX = 7
) (
  ref_clk,
  rst,
  drumClk,
  opMode,
  buttonZero,
  buttonOne,
  refMark,
  clearR,
  clearY,
  clearZ,
  sectSelect,
  rTrackIn,
  yTrackIn,
  rTrackOut,
  yTrackOut,
  zTrackOut,
  slotNum,
  sectNum,
  goActive,
  fillBit
);
  input wire logic ref_clk;
  input wire logic rst;
  input wire logic drumClk;
  input wire dsi_pkg::dsi_op_type opMode;
  input wire logic buttonZero;
  input wire logic buttonOne;
  input wire logic refMark;
  input wire logic clearR;
  input wire logic clearY;
  input wire logic clearZ;
  input wire logic [4:0] sectSelect;
  input wire logic rTrackIn;
  input wire logic yTrackIn;
  output logic rTrackOut;
  output logic yTrackOut;
  output logic zTrackOut;
  output logic [5:0] slotNum;
  output logic [4:0] sectNum;
  output logic goActive;
  output logic fillBit;

  initial begin
    if (DY_MAX < 1 || DY_MAX > 7) begin
      $error("DY_MAX must be 1..7");
    end
    if (DY_W < 2) begin
      $error("DY_W too narrow for a signed dy count");
    end
    if (DY_MAX > (1 << (DY_W - 1)) - 1) begin
      $error("DY_MAX exceeds the signed dy range");
    end
    if (OVF_LEN_MAX != SLOTS + 1) begin
      $error("Overflow line must be one slot longer than a section");
    end
  end

  // Panel controls cross from the ref_clk domain onto the drum clock
  dsi_sync_if ctlIf();
  logic [5:0] panel_q;
  logic [4:0] sectSelDrum;
  logic [2:0] opDrum;

  // Panel pins sampled twice on ref_clk first, then bundled
  logic [5:0] panelRaw;
  assign panelRaw = {refMark, clearZ, clearY, clearR, buttonOne, buttonZero};
  dsi_sync2 #(.W(6)) uPanelRef (
    .clk(ref_clk),
    .rst(rst),
    .din(panelRaw),
    .dout(panel_q)
  );
  assign ctlIf.ctl = panel_q;
  dsi_sync2 #(.W(6)) uPanelDrum (
    .clk(drumClk),
    .rst(rst),
    .din(ctlIf.ctl),
    .dout(ctlIf.ctlSync)
  );
  // Mode and section switches are static while in use
  dsi_sync2 #(.W(8)) uSwitch (
    .clk(drumClk),
    .rst(rst),
    .din({opMode, sectSelect}),
    .dout({opDrum, sectSelDrum})
  );

  // Whole datapath state in one register so every bit moves on the
  // same drum edge; the overflow line is the widest part and sets the
  // area, which is why it is a plain shift chain with three taps rather
  // than a memory.
  typedef struct packed {
    logic [5:0] slot;
    logic [4:0] sect;
    logic [OVF_LEN_MAX-1:0] zLine;
    logic incr;
    logic start;
    logic [DY_W-1:0] dy;
    logic carryR;
    logic carryY;
    logic ovfBit;
    logic reverse;
    logic go;
    logic goArm;
    logic fill;
    logic btnPrev;
    logic rOut;
    logic yOut;
    logic zOut;
  } dsi_state_type;

  dsi_state_type st_q;
  dsi_state_type st_d;

  logic btnZ;
  logic btnO;
  logic clrR;
  logic clrY;
  logic clrZ;
  logic mark;
  assign {mark, clrZ, clrY, clrR, btnO, btnZ} = ctlIf.ctlSync;

  // Overflow line taps: Za at 48, Zb at 49, short tap at 47
  // Reading a tap one stage earlier shortens the loop by one slot, which
  // is how fill and step right move the reference pulse against the counters
  logic zTap47;
  logic zTap48;
  logic zTap49;
  assign zTap47 = st_q.zLine[OVF_LEN_MAX-3];
  assign zTap48 = st_q.zLine[OVF_LEN_MAX-2];
  assign zTap49 = st_q.zLine[OVF_LEN_MAX-1];

  logic inSelSect;
  assign inSelSect = (st_q.sect == sectSelDrum);

  always_comb begin
    logic codeSlot;
    logic numeric;
    logic yEff;
    logic sumR;
    logic cR;
    logic [DY_W:0] ySum;
    logic dyBit;
    logic zFeed;
    logic zPick;
    logic secEnd;
    logic revEnd;
    logic press;
    codeSlot = 1'b0;
    numeric = 1'b0;
    yEff = 1'b0;
    sumR = 1'b0;
    cR = 1'b0;
    ySum = '0;
    dyBit = 1'b0;
    zFeed = 1'b0;
    zPick = 1'b0;
    secEnd = 1'b0;
    revEnd = 1'b0;
    press = 1'b0;
    st_d = st_q;

    // Slot and section counters
    secEnd = (st_q.slot == SLOT_LAST);
    revEnd = secEnd && (st_q.sect == SECT_LAST);
    st_d.slot = secEnd ? SLOT_FIRST : st_q.slot + 6'h01;
    if (secEnd) begin
      st_d.sect = (st_q.sect == SECT_LAST) ? 5'h00 : st_q.sect + 5'h01;
    end

    // Bit read at the Zb tap; one extra stage per section gives precession
    zPick = zTap49;
    codeSlot = (st_q.slot <= SLOT_CODE_END);
    numeric = st_q.start && !codeSlot && (st_q.slot != SLOT_LAST);

    // Code half: R pulse latches increment, Y pulses step dy
    // Pickup code lives in slots 1..22 only; slot 23 is blank and slot 24
    // may carry the Y start pulse, which must not be counted as a pickup.
    // Count saturates upward at DY_MAX; downward steps have no floor, so a busy code field can wrap.
    if (codeSlot && rTrackIn) begin
      st_d.incr = zPick;
    end
    if (yTrackIn && st_q.slot < SLOT_START_AFTER) begin
      if (zPick && st_q.dy != DY_W'(DY_MAX)) begin
        st_d.dy = st_q.dy + 4'h1;
      end else if (!zPick) begin
        st_d.dy = st_q.dy - 4'h1;
      end
    end
    if (!st_q.start && st_q.slot > SLOT_START_AFTER && yTrackIn) begin
      st_d.start = 1'b1;
    end

    // Carry preset; subtract adds one to the inverted Y
    if (st_q.slot == SLOT_CARRY_PRESET) begin
      st_d.carryR = !st_q.incr;
      st_d.carryY = 1'b0;
    end

    // Serial adders, LSB first right after start
    // Both adders see the same Y bit; the R+Y side takes it inverted when
    // subtracting and relies on the preset carry for the extra one. The
    // dy count streams out LSB first and sign-extends, so a negative
    // count subtracts cleanly across the whole Y word.
    yEff = st_q.incr ? yTrackIn : !yTrackIn;
    sumR = rTrackIn ^ yEff ^ st_q.carryR;
    cR = (rTrackIn & yEff) | (st_q.carryR & (rTrackIn | yEff));
    dyBit = st_q.dy[0];
    ySum = {4'h0, yTrackIn} + {4'h0, dyBit} + {4'h0, st_q.carryY};
    st_d.rOut = rTrackIn;
    st_d.yOut = yTrackIn;
    if (numeric) begin
      st_d.carryR = cR;
      st_d.carryY = ySum[1];
      st_d.rOut = sumR;
      st_d.yOut = ySum[0];
      // Sign-extend dy as it streams out
      st_d.dy = {st_q.dy[DY_W-1], st_q.dy[DY_W-1:1]};
    end
    if (st_q.slot == SLOT_SIGN && numeric) begin
      st_d.reverse = 1'b0;
    end
    // Sign slot is the top of Y; carry into it flips sign as positive=1 wraps
    if (st_q.slot == SLOT_SIGN) begin
      st_d.yOut = numeric ? ySum[0] : yTrackIn;
    end

    // Slot 48: R sum bit becomes overflow, R bit kept, Y forced zero
    // The sum bit here would be the carry-out of the R word; it is used
    // as the overflow pulse and folded with the reversal bit held in R's
    // own slot 48, which itself is never rewritten by the adder.
    if (st_q.slot == SLOT_OVF) begin
      st_d.reverse = rTrackIn;
      st_d.ovfBit = (st_q.start ? (rTrackIn ^ yEff ^ st_q.carryR) : 1'b0) ^ rTrackIn;
      st_d.rOut = rTrackIn;
      st_d.yOut = 1'b0;
    end

    // Overflow line length select and write gate
    // Idle: loop of 48 through the Za tap so the pattern stands still.
    // Computing: loop of 49 through Zb so each overflow precesses one slot.
    // Fill and step right shorten to 47 in the chosen section only; step
    // left lengthens to 49 there, moving the reference the other way.
    zFeed = zTap49;
    if (st_q.go && inSelSect) begin
      case (opDrum)
        OP_FILL_Y, OP_FILL_R, OP_STEP_RIGHT: zFeed = zTap47;
        OP_STEP_LEFT: zFeed = zTap49;
        default: zFeed = zTap49;
      endcase
    end else if (!st_q.go) begin
      zFeed = zTap48;
    end
    if (st_q.slot == SLOT_OVF && st_q.go && (opDrum == OP_ONE_REV || opDrum == OP_COMPUTE)) begin
      zFeed = st_d.ovfBit;
    end
    if (mark && st_q.slot == SLOT_OVF) begin
      zFeed = 1'b1;
    end
    st_d.zLine = {st_q.zLine[OVF_LEN_MAX-2:0], zFeed};
    st_d.zOut = zFeed;

    // Fill modes record the held fill bit against the Za reference
    if (st_q.go && inSelSect && zTap48) begin
      if (opDrum == OP_FILL_Y) begin
        st_d.yOut = st_q.fill;
      end
      if (opDrum == OP_FILL_R) begin
        st_d.rOut = st_q.fill;
      end
    end

    // Buttons arm go; go runs whole revolutions only
    // Go only changes between the last and first section, so a press
    // in mid-revolution waits; a press landing on that same edge is kept
    // armed for the following revolution instead of being lost.
    press = (btnZ || btnO) && !st_q.btnPrev;
    st_d.btnPrev = btnZ || btnO;
    if (press) begin
      st_d.goArm = 1'b1;
      st_d.fill = btnO;
    end
    if (revEnd) begin
      if (st_q.goArm) begin
        st_d.go = 1'b1;
        st_d.goArm = press;
      end else if (opDrum != OP_COMPUTE) begin
        st_d.go = 1'b0;
      end
    end

    // Clears erase whole tracks while held
    // An R or Y clear must be held for a full revolution to erase every section, while a Z clear empties the whole overflow line on one edge;
    // it wins over fill, marker and computed bits alike.
    if (clrR) begin
      st_d.rOut = 1'b0;
    end
    if (clrY) begin
      st_d.yOut = 1'b0;
    end
    if (clrZ) begin
      st_d.zLine = '0;
      st_d.zOut = 1'b0;
    end

    // Fresh state for each integrator
    if (secEnd) begin
      st_d.start = 1'b0;
      st_d.dy = '0;
    end
  end

  // Panel levels arrive four edges late, so a clear or marker reaches
  // the datapath only that long after its pin changes.
  // Whole state advances on the drum clock; reset gives slot 1 of section 0
  always_ff @(posedge drumClk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.slot <= SLOT_FIRST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rTrackOut = st_q.rOut;
  assign yTrackOut = st_q.yOut;
  assign zTrackOut = st_q.zOut;
  assign slotNum = st_q.slot;
  assign sectNum = st_q.sect;
  assign goActive = st_q.go;
  assign fillBit = st_q.fill;
endmodule : drum_serial_integrator_core

// *** verilog/dsi_pkg.sv ***
/*
  Constants and types of the drum serial integrator core.
  Assumes slots are numbered 1..48 within a section and sections 0..21.
*/
package dsi_pkg;
  localparam int SLOTS = 48;
  localparam int SECTIONS = 22;
  localparam logic [5:0] SLOT_FIRST = 6'h01;
  localparam logic [5:0] SLOT_LAST = 6'h30;
  localparam logic [5:0] SLOT_CODE_END = 6'h18;
  localparam logic [5:0] SLOT_START_AFTER = 6'h17;
  localparam logic [5:0] SLOT_CARRY_PRESET = 6'h18;
  localparam logic [5:0] SLOT_SIGN = 6'h2F;
  localparam logic [5:0] SLOT_OVF = 6'h30;
  localparam logic [4:0] SECT_LAST = 5'h15;
  localparam int OVF_LEN_MAX = 49;
  localparam int DY_W = 4;

  typedef enum logic [2:0] {
    OP_FILL_Y = 3'b000,
    OP_FILL_R = 3'b001,
    OP_STEP_LEFT = 3'b010,
    OP_STEP_RIGHT = 3'b011,
    OP_ONE_REV = 3'b100,
    OP_COMPUTE = 3'b101
  } dsi_op_type;
endpackage : dsi_pkg

// *** verilog/dsi_sync_if.sv ***
/*
  Carrier between the core and its crossing helpers.
  Assumes one producer and one consumer per signal group.
*/
`timescale 1ns/1ps
interface dsi_sync_if;
  logic [5:0] ctl;
  logic [5:0] ctlSync;
  modport src (output ctl);
  modport dst (input ctlSync);
  modport sync (input ctl, output ctlSync);
endinterface : dsi_sync_if

// *** verilog/dsi_sync2.sv ***
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level; no word coherence is promised.
*/
`timescale 1ns/1ps
module dsi_sync2 #(
  parameter int W = 1
) (
  clk,
  rst,
  din,
  dout
);
  input wire logic clk;
  input wire logic rst;
  input wire logic [W-1:0] din;
  output logic [W-1:0] dout;
  logic [W-1:0] meta_q;

  // First stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : dsi_sync2

// *** tb/dsi_properties.sv ***
/*
  Pin checks of the integrator core on the drum clock.
  Assumes panel pins reach the datapath within six drum clocks.
*/
`timescale 1ns/1ps
module dsi_props
  import dsi_pkg::*;
#(
  parameter int DY_MAX = 7
) (
  input wire logic rst,
  input wire logic drumClk,
  input wire dsi_pkg::dsi_op_type opMode,
  input wire logic refMark,
  input wire logic clearR,
  input wire logic clearY,
  input wire logic clearZ,
  input wire logic rTrackIn,
  input wire logic yTrackIn,
  input wire logic rTrackOut,
  input wire logic yTrackOut,
  input wire logic zTrackOut,
  input wire logic [5:0] slotNum,
  input wire logic [4:0] sectNum,
  input wire logic goActive
);
  default clocking cb @(posedge drumClk); endclocking
  default disable iff (rst);
  // Position counters
  property p_slot; slotNum != SLOT_LAST |=> slotNum == $past(slotNum) + 6'h01; endproperty
  property p_wrap; slotNum == SLOT_LAST |=> slotNum == SLOT_FIRST; endproperty
  property p_sect;
    slotNum == SLOT_LAST |=> sectNum == ($past(sectNum) == SECT_LAST ? 5'h00 : $past(sectNum) + 5'h01);
  endproperty
  // Fixed slots; settle time for panel levels
  property p_y48; slotNum == SLOT_OVF && opMode != OP_FILL_Y |=> !yTrackOut; endproperty
  property p_r48; (!clearR)[*6] ##0 (slotNum == SLOT_OVF && opMode != OP_FILL_R) |=> rTrackOut == $past(rTrackIn); endproperty
  property p_clr; (clearR && clearY && clearZ)[*6] |=> !rTrackOut && !yTrackOut && !zTrackOut; endproperty
  property p_ref; (refMark && !clearZ)[*6] ##0 slotNum == SLOT_OVF |=> zTrackOut; endproperty
  property p_go; goActive != $past(goActive) |-> $past(slotNum) == SLOT_LAST && $past(sectNum) == SECT_LAST; endproperty
  property p_code;
    (!clearR && !clearY)[*6] ##0 (slotNum <= SLOT_CODE_END && !goActive)
      |=> rTrackOut == $past(rTrackIn) && yTrackOut == $past(yTrackIn);
  endproperty
  a_slot: assert property (p_slot) else $error("slot step");
  a_wrap: assert property (p_wrap) else $error("slot wrap");
  a_sect: assert property (p_sect) else $error("section step");
  a_y48: assert property (p_y48) else $error("Y slot 48");
  a_r48: assert property (p_r48) else $error("R slot 48");
  a_clr: assert property (p_clr) else $error("clear");
  a_ref: assert property (p_ref) else $error("marker");
  a_go: assert property (p_go) else $error("go edge");
  a_code: assert property (p_code) else $error("code slots");
  c_go: cover property (goActive && slotNum == SLOT_OVF);
  c_clr: cover property (clearR && clearY && clearZ);
  c_ref: cover property (refMark && slotNum == SLOT_OVF);
endmodule : dsi_props

bind drum_serial_integrator_core dsi_props #(.DY_MAX(DY_MAX)) dsi_props_i (.*);

// *** tb/dsi_drum_model.sv ***
/*
  Drum model: R and Y tracks, 22 sections of 48 slots, spinning freely.
  Assumes the core writes each slot one drum clock after reading it.
*/
`timescale 1ns/1ps
module dsi_drum_model (
  input wire logic rst,
  input wire logic drumClk,
  input wire logic rTrackOut,
  input wire logic yTrackOut,
  output logic rTrackIn,
  output logic yTrackIn
);
  logic [1055:0] rMem = '0;
  logic [1055:0] yMem = '0;
  int pos = 0;
  int prev = -1;
  // Write head trails the read head by one slot
  always @(posedge drumClk or posedge rst) begin
    if (rst) begin
      pos <= 0;
      prev <= -1;
    end else begin
      if (prev >= 0) begin
        rMem[prev] <= rTrackOut;
        yMem[prev] <= yTrackOut;
      end
      prev <= pos;
      pos <= (pos == 1055) ? 0 : pos + 1;
    end
  end
  // Heads read the slot under them
  assign rTrackIn = rMem[pos];
  assign yTrackIn = yMem[pos];
endmodule : dsi_drum_model

// *** tb/drum_serial_integrator_core_tb.sv ***
/*
  Bench for the drum integrator core, driving the panel against a drum model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module drum_serial_integrator_core_tb;
  import dsi_pkg::*;
  logic ref_clk = 1'h0;
  logic drumClk = 1'h0;
  logic rst = 1'h1;
  dsi_op_type opMode = OP_ONE_REV;
  logic buttonZero = 1'h0;
  logic buttonOne = 1'h0;
  logic refMark = 1'h0;
  logic clearR = 1'h0;
  logic clearY = 1'h0;
  logic clearZ = 1'h0;
  logic [4:0] sectSelect = 5'h03;
  logic rTrackIn, yTrackIn, rTrackOut, yTrackOut, zTrackOut, goActive, fillBit;
  logic [5:0] slotNum;
  logic [4:0] sectNum;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  // Periods of 10 and 12 ns drift against each other
  always #5 ref_clk = ~ref_clk;
  always #6 drumClk = ~drumClk;
  drum_serial_integrator_core #(.DY_MAX(7)) drum_serial_integrator_core_i (.*);
  dsi_drum_model dsi_drum_model_i (.*);
  // Hang guard, about twice the expected run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [22:0] exp, logic [22:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_go(logic lvl);
    int n;
    n = 0;
    while (goActive !== lvl && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("goActive", 23'(lvl), 23'(goActive));
  endtask : wait_go
  task automatic press(logic one);
    @(negedge ref_clk);
    buttonOne = one;
    buttonZero = !one;
    repeat (20) @(negedge ref_clk);
    buttonOne = 1'h0;
    buttonZero = 1'h0;
  endtask : press
  // Held over a full revolution so every section sees it
  task automatic panel(logic [3:0] v);
    @(negedge ref_clk);
    {clearR, clearY, clearZ, refMark} = v;
    repeat (1400) @(negedge ref_clk);
    {clearR, clearY, clearZ, refMark} = 4'h0;
    repeat (10) @(negedge ref_clk);
  endtask : panel
  // Marker gives z one at slot 1, a cleared line gives zero
  task automatic arith(logic add, int st, logic [22:0] rv, logic [22:0] yv);
    logic [22:0] m;
    logic [22:0] e;
    m = 23'((1 << (47 - st)) - 1);
    panel(add ? 4'hD : 4'hE);
    while (sectNum !== 5'h0A) @(negedge ref_clk);
    dsi_drum_model_i.rMem[st +: 23] = rv;
    dsi_drum_model_i.yMem[st +: 23] = yv;
    dsi_drum_model_i.rMem[0] = 1'h1;
    dsi_drum_model_i.yMem[st - 1] = 1'h1;
    dsi_drum_model_i.rMem[47] = 1'h1;
    dsi_drum_model_i.yMem[47] = 1'h1;
    opMode = OP_ONE_REV;
    press(1'h1);
    wait_go(1'h1);
    wait_go(1'h0);
    e = add ? rv + yv : rv - yv;
    chk("R word", e & m, 23'(dsi_drum_model_i.rMem >> st) & m);
    chk("R slot 48", 23'h1, 23'(dsi_drum_model_i.rMem[47]));
    chk("Y slot 48", 23'h0, 23'(dsi_drum_model_i.yMem[47]));
    chk("Y word", yv & m, 23'(dsi_drum_model_i.yMem >> st) & m);
    $display("arith add %0d start %0d done", add, st);
  endtask : arith
  // Main sequence
  initial begin
    rst = 1'h1;
    repeat (5) @(negedge ref_clk);
    chk("reset slot", 23'h1, 23'(slotNum));
    chk("reset sect", 23'h0, 23'(sectNum));
    rst = 1'h0;
    arith(1'h0, 24, 23'h000105, 23'h400003);
    arith(1'h1, 24, 23'h000105, 23'h400003);
    arith(1'h0, 30, 23'h000105, 23'h010003);
    for (int i = 0; i < 6; i++) begin
      opMode = dsi_op_type'(3'(i));
      press(i[0]);
      wait_go(1'h1);
      if (i < 5) wait_go(1'h0);
      chk("fill bit", 23'(i[0]), 23'(fillBit));
      $display("mode %0d done", i);
    end
    report_and_stop();
  end
endmodule : drum_serial_integrator_core_tb
